// [pkg/vic_pkg.sv]
package vic_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_MF_A   = 8'h08;
  localparam logic [7:0] OFS_MF_B   = 8'h0c;
  localparam logic [7:0] OFS_EDGE   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // main source indices, lowest index is highest priority
  localparam int NUM_MAIN = 6;
  localparam int NUM_SUB  = 7;
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 1;
  localparam int SRC_TMR_A = 2;
  localparam int SRC_TMR_B = 3;
  localparam int SRC_SER   = 4;
  localparam int SRC_MF    = 5;
  // vector table
  localparam logic [7:0] VECTOR [NUM_MAIN] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  // field positions
  localparam int GLOBAL_EN_BIT = 0;
  localparam int CTRL_A_EN_LSB = 1;
  localparam int CTRL_A_FL_LSB = 4;
  localparam int CTRL_B_EN_LSB = 0;
  localparam int CTRL_B_FL_LSB = 4;
  localparam int MF_A_EN_LSB   = 0;
  localparam int MF_A_FL_LSB   = 4;
  localparam int MF_B_EN_LSB   = 0;
  localparam int MF_B_FL_LSB   = 4;
  // reset values
  localparam logic [NUM_MAIN-1:0] MAIN_RST = 6'h00;
  localparam logic [NUM_SUB-1:0]  SUB_RST  = 7'h00;
  localparam logic [3:0]          EDGE_RST = 4'h0;
  // edge select codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // internal and pin events, one-cycle pulses or pin levels
  typedef struct packed {
    logic timerAOvf;
    logic timerBOvf;
    logic serialDone;
    logic convDone;
    logic timebaseATick;
    logic timebaseBTick;
    logic cmpEvent;
    logic eepromDone;
    logic lowVoltEvent;
    logic extIrqPinA;
    logic extIrqPinB;
    logic periphIrqPin;
  } vic_src_t;

  // requests to the core sequencer
  typedef struct packed {
    logic        pcLoad;
    logic [15:0] pcLoadValue;
    logic        stackPush;
    logic [15:0] stackPushData;
    logic        stackPop;
  } vic_cpu_t;
endpackage

// [rtl/vic_controller.sv]
module vic_controller #(
  parameter int ADDR_W = 8,
  parameter int PC_W   = 12
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire vic_pkg::vic_src_t src,
  input  wire logic              corePhasePulse,
  input  wire logic              stackFull,
  input  wire logic              returnFromInterrupt,
  input  wire logic [PC_W-1:0]   pcNext,
  input  wire logic [PC_W-1:0]   stackTopData,
  output vic_pkg::vic_cpu_t      cpu
);
  localparam int NM = vic_pkg::NUM_MAIN;
  localparam int NS = vic_pkg::NUM_SUB;

  logic          globalEn_q;
  logic [NM-1:0] mainEn_q;
  logic [NM-1:0] mainFlag_q;
  logic [NS-1:0] subEn_q;
  logic [NS-1:0] subFlag_q;
  logic [3:0]    edgeSel_q;
  logic [2:0]    pinPrev_q;
  logic [7:0]    lastVector_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [31:0]   prdata_q;
  vic_pkg::vic_cpu_t cpu_q;

  logic          wrEn;
  logic          wrCtrlA;
  logic          wrCtrlB;
  logic          wrMfA;
  logic          wrMfB;
  logic          wrEdge;
  logic [7:0]    wByte;
  logic          pinARise;
  logic          pinAFall;
  logic          pinBRise;
  logic          pinBFall;
  logic [NS-1:0] subEvent;
  logic [NS-1:0] subSet;
  logic [NM-1:0] mainSet;
  logic [NM-1:0] mainWrEn;
  logic [NM-1:0] mainWrVal;
  logic [NM-1:0] pendEn;
  logic [NM-1:0] serviceClr;
  logic [2:0]    winner;
  logic          takeNow;
  logic          mapped;
  logic [7:0]    rdByte;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign cpu     = cpu_q;

  // apb write strobes, taken at the access edge only
  assign wrEn    = psel && penable && pready_q && pwrite;
  assign wByte   = pwdata[7:0];
  assign wrCtrlA = wrEn && (paddr[7:0] == vic_pkg::OFS_CTRL_A);
  assign wrCtrlB = wrEn && (paddr[7:0] == vic_pkg::OFS_CTRL_B);
  assign wrMfA   = wrEn && (paddr[7:0] == vic_pkg::OFS_MF_A);
  assign wrMfB   = wrEn && (paddr[7:0] == vic_pkg::OFS_MF_B);
  assign wrEdge  = wrEn && (paddr[7:0] == vic_pkg::OFS_EDGE);

  // pin edge detection against the previous sample
  assign pinARise = src.extIrqPinA && !pinPrev_q[0];
  assign pinAFall = !src.extIrqPinA && pinPrev_q[0];
  assign pinBRise = src.extIrqPinB && !pinPrev_q[1];
  assign pinBFall = !src.extIrqPinB && pinPrev_q[1];

  // sub-source events in register bit order
  assign subEvent = {src.lowVoltEvent, src.eepromDone, src.cmpEvent,
                     !src.periphIrqPin && pinPrev_q[2],
                     src.timebaseBTick, src.timebaseATick, src.convDone};
  assign subSet   = subEvent & subEn_q;

  // main source set requests
  always_comb begin
    mainSet = '0;
    mainSet[vic_pkg::SRC_EXT_A] = ((edgeSel_q[1:0] == vic_pkg::EDGE_RISE) && pinARise) ||
                                  ((edgeSel_q[1:0] == vic_pkg::EDGE_FALL) && pinAFall) ||
                                  ((edgeSel_q[1:0] == vic_pkg::EDGE_BOTH) && (pinARise || pinAFall));
    mainSet[vic_pkg::SRC_EXT_B] = ((edgeSel_q[3:2] == vic_pkg::EDGE_RISE) && pinBRise) ||
                                  ((edgeSel_q[3:2] == vic_pkg::EDGE_FALL) && pinBFall) ||
                                  ((edgeSel_q[3:2] == vic_pkg::EDGE_BOTH) && (pinBRise || pinBFall));
    mainSet[vic_pkg::SRC_TMR_A] = src.timerAOvf;
    mainSet[vic_pkg::SRC_TMR_B] = src.timerBOvf;
    mainSet[vic_pkg::SRC_SER]   = src.serialDone;
    mainSet[vic_pkg::SRC_MF]    = |subSet;
  end

  // software write of main flags, split across the two control registers
  always_comb begin
    mainWrEn  = '0;
    mainWrVal = '0;
    for (int i = 0; i < 3; i++) begin
      mainWrEn[i]    = wrCtrlA;
      mainWrVal[i]   = wByte[vic_pkg::CTRL_A_FL_LSB + i];
      mainWrEn[i+3]  = wrCtrlB;
      mainWrVal[i+3] = wByte[vic_pkg::CTRL_B_FL_LSB + i];
    end
  end

  // fixed priority pick, lowest index first
  assign pendEn = mainFlag_q & mainEn_q;
  always_comb begin
    winner = 3'(NM - 1);
    for (int i = NM - 1; i >= 0; i--) begin
      if (pendEn[i]) begin
        winner = 3'(i);
      end
    end
  end

  // acceptance only on a phase pulse, global enable set, stack not full
  assign takeNow = corePhasePulse && globalEn_q && !stackFull && (|pendEn)
                   && !returnFromInterrupt;

  // service clears the winner flag; multifunction clears only the common flag
  always_comb begin
    serviceClr = '0;
    if (takeNow) begin
      serviceClr[winner] = 1'b1;
    end
  end

  // per-source request flags, hardware set wins
  for (genvar g = 0; g < NM; g++) begin : gMain
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        mainFlag_q[g] <= 1'b0;
      end else if (mainSet[g]) begin
        mainFlag_q[g] <= 1'b1;
      end else if (mainWrEn[g]) begin
        mainFlag_q[g] <= mainWrVal[g];
      end else if (serviceClr[g]) begin
        mainFlag_q[g] <= 1'b0;
      end
    end
  end

  // sub-source flags, cleared only by software
  for (genvar g = 0; g < NS; g++) begin : gSub
    // flag bit and write strobe of the register holding this sub-source
    localparam int FL_BIT = (g < 4) ? vic_pkg::MF_A_FL_LSB + g : vic_pkg::MF_B_FL_LSB + g - 4;
    logic wrSub;
    assign wrSub = (g < 4) ? wrMfA : wrMfB;
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        subFlag_q[g] <= 1'b0;
      end else if (subEvent[g]) begin
        subFlag_q[g] <= 1'b1;
      end else if (wrSub) begin
        subFlag_q[g] <= wByte[FL_BIT];
      end
    end
  end

  // global enable, cleared on acceptance; software may set it again
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      globalEn_q <= 1'b0;
    end else if (takeNow) begin
      globalEn_q <= 1'b0;
    end else if (wrCtrlA) begin
      globalEn_q <= wByte[vic_pkg::GLOBAL_EN_BIT];
    end
  end

  // enable bits and edge select
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mainEn_q  <= vic_pkg::MAIN_RST;
      subEn_q   <= vic_pkg::SUB_RST;
      edgeSel_q <= vic_pkg::EDGE_RST;
    end else begin
      if (wrCtrlA) begin
        mainEn_q[2:0] <= wByte[vic_pkg::CTRL_A_EN_LSB +: 3];
      end
      if (wrCtrlB) begin
        mainEn_q[5:3] <= wByte[vic_pkg::CTRL_B_EN_LSB +: 3];
      end
      if (wrMfA) begin
        subEn_q[3:0] <= wByte[vic_pkg::MF_A_EN_LSB +: 4];
      end
      if (wrMfB) begin
        subEn_q[6:4] <= wByte[vic_pkg::MF_B_EN_LSB +: 3];
      end
      if (wrEdge) begin
        edgeSel_q <= wByte[3:0];
      end
    end
  end

  // previous pin samples for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinPrev_q <= 3'h7;
    end else begin
      pinPrev_q <= {src.periphIrqPin, src.extIrqPinB, src.extIrqPinA};
    end
  end

  // core requests: vector entry or return
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_q        <= '0;
      lastVector_q <= 8'h00;
    end else begin
      cpu_q.pcLoad    <= takeNow || returnFromInterrupt;
      cpu_q.stackPush <= takeNow;
      cpu_q.stackPop  <= returnFromInterrupt;
      if (returnFromInterrupt) begin
        cpu_q.pcLoadValue <= 16'(stackTopData);
      end else if (takeNow) begin
        cpu_q.pcLoadValue   <= 16'(vic_pkg::VECTOR[winner]);
        cpu_q.stackPushData <= 16'(pcNext);
        lastVector_q        <= vic_pkg::VECTOR[winner];
      end
    end
  end

  // read mux, unimplemented bits zero
  always_comb begin
    mapped = 1'b1;
    rdByte = 8'h00;
    if (paddr[7:0] == vic_pkg::OFS_CTRL_A) begin
      rdByte = {1'b0, mainFlag_q[2:0], mainEn_q[2:0], globalEn_q};
    end else if (paddr[7:0] == vic_pkg::OFS_CTRL_B) begin
      rdByte = {1'b0, mainFlag_q[5:3], 1'b0, mainEn_q[5:3]};
    end else if (paddr[7:0] == vic_pkg::OFS_MF_A) begin
      rdByte = {subFlag_q[3:0], subEn_q[3:0]};
    end else if (paddr[7:0] == vic_pkg::OFS_MF_B) begin
      rdByte = {1'b0, subFlag_q[6:4], 1'b0, subEn_q[6:4]};
    end else if (paddr[7:0] == vic_pkg::OFS_EDGE) begin
      rdByte = {4'h0, edgeSel_q};
    end else if (paddr[7:0] == vic_pkg::OFS_STATUS) begin
      rdByte = lastVector_q;
    end else begin
      mapped = 1'b0;
    end
    if ((paddr >> 8) != '0 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
      rdByte = 8'h00;
    end
  end

  // apb answer: ready in the first access cycle, no wait states
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata_q <= {24'h00_0000, rdByte};
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seqPinARise;
    (edgeSel_q[1:0] == vic_pkg::EDGE_RISE) && !src.extIrqPinA ##1 src.extIrqPinA;
  endsequence
  sequence seqTake;
    takeNow ##1 cpu_q.stackPush;
  endsequence

  AST_GLOBAL_GATE: assert property (cpu_q.stackPush |-> $past(globalEn_q))
    else $error("entry taken with global enable low");
  AST_PUSH_VECTOR: assert property (takeNow |=> cpu_q.pcLoad && cpu_q.stackPush
    && cpu_q.stackPushData == 16'($past(pcNext)))
    else $error("entry did not push pc");
  AST_RETURN: assert property (returnFromInterrupt |=> cpu_q.stackPop && cpu_q.pcLoad
    && cpu_q.pcLoadValue == 16'($past(stackTopData)) && !cpu_q.stackPush)
    else $error("return did not pop pc");
  AST_GLOBAL_CLR: assert property (seqTake |-> !globalEn_q)
    else $error("global enable not cleared on entry");
  AST_PENDING: assert property (mainSet[vic_pkg::SRC_TMR_A] && !globalEn_q
    |=> mainFlag_q[vic_pkg::SRC_TMR_A] [*2])
    else $error("blocked request lost");
  AST_STACK_FULL: assert property (stackFull |=> !cpu_q.stackPush)
    else $error("entry taken with full stack");
  AST_PHASE: assert property (cpu_q.stackPush |-> $past(corePhasePulse))
    else $error("entry off the phase pulse");
  AST_PRIO_TOP: assert property (takeNow && pendEn[vic_pkg::SRC_EXT_A]
    |=> cpu_q.pcLoadValue == 16'h0004)
    else $error("pin a not first priority");
  AST_PRIO_LOW: assert property (takeNow && pendEn == 6'h20
    |=> cpu_q.pcLoadValue == 16'h0018 && !mainFlag_q[vic_pkg::SRC_MF])
    else $error("multifunction vector wrong");
  AST_SUB_KEEP: assert property (takeNow && winner == 3'(vic_pkg::SRC_MF) && (|subFlag_q)
    |=> (|subFlag_q))
    else $error("sub flag cleared by hardware");
  AST_EDGE_A: assert property (seqPinARise |=> mainFlag_q[vic_pkg::SRC_EXT_A])
    else $error("rising edge on pin a missed");
  AST_SET_WINS: assert property (wrCtrlA && !wByte[vic_pkg::CTRL_A_FL_LSB + 2]
    && mainSet[vic_pkg::SRC_TMR_A] |=> mainFlag_q[vic_pkg::SRC_TMR_A])
    else $error("set lost to software clear");
  AST_MF_RAISE: assert property ((|subSet) |=> mainFlag_q[vic_pkg::SRC_MF])
    else $error("common flag not raised");
endmodule

// [tb/testbench.sv]
// self-checking bench for the vectored interrupt controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk, reset_n, psel, penable, pwrite, forceFull, retCmd;
  logic              pready, pslverr, corePhasePulse, stackFull, returnFromInterrupt, e;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, d, rv;
  logic [11:0]       pcNext, stackTopData, pcPrev, lastPush;
  logic [5:0]        m, m2;
  logic [16:0]       expQ [$];
  logic [16:0]       note;
  vic_pkg::vic_src_t src;
  vic_pkg::vic_cpu_t cpu;
  int                err_count, n_tests, seed;
  // event table: register touched and value read back after one pulse
  localparam logic [7:0] EV_OFS [9] = '{vic_pkg::OFS_CTRL_A, vic_pkg::OFS_CTRL_B,
    vic_pkg::OFS_CTRL_B, vic_pkg::OFS_MF_A, vic_pkg::OFS_MF_A, vic_pkg::OFS_MF_A,
    vic_pkg::OFS_MF_B, vic_pkg::OFS_MF_B, vic_pkg::OFS_MF_B};
  localparam logic [7:0] EV_EXP [9] = '{8'h40, 8'h10, 8'h20, 8'h1f, 8'h2f, 8'h4f,
    8'h17, 8'h27, 8'h47};

  vic_controller i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src(src), .corePhasePulse(corePhasePulse),
    .stackFull(stackFull), .returnFromInterrupt(returnFromInterrupt), .pcNext(pcNext),
    .stackTopData(stackTopData), .cpu(cpu));
  vic_core_model i_core (.core_clk(core_clk), .reset_n(reset_n), .forceFull(forceFull),
    .retCmd(retCmd), .cpu(cpu), .corePhasePulse(corePhasePulse), .stackFull(stackFull),
    .returnFromInterrupt(returnFromInterrupt), .pcNext(pcNext), .stackTopData(stackTopData));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, d, e);
    chk(name, d, {24'h0, exp});
  endtask

  // wait until every noted redirect has been seen
  task automatic drain();
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("pending redirects", expQ.size(), 0);
  endtask

  // monitor: each redirect takes the oldest note off the queue
  always @(posedge core_clk) begin
    pcPrev <= pcNext;
    if (reset_n && cpu.pcLoad) begin
      if (expQ.size() == 0) begin
        chk("unexpected pcLoad", cpu.pcLoadValue, 16'hffff);
      end else begin
        note = expQ.pop_front();
        chk("pcLoadValue", cpu.pcLoadValue, note[15:0]);
        chk("stackPop", cpu.stackPop, note[16]);
        chk("stackPush", cpu.stackPush, !note[16]);
      end
      if (cpu.stackPush) begin
        chk("stackPushData", cpu.stackPushData, {4'h0, pcPrev});
        lastPush <= pcPrev;
      end
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    complete_run();
  end

  initial begin
    seed = 32'h35c9;
    {reset_n, psel, penable, pwrite, forceFull, retCmd} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 12'h007;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset values, refused addresses, read/write masks
    rdc("ctrl_a", vic_pkg::OFS_CTRL_A, 8'h00);
    rdc("ctrl_b", vic_pkg::OFS_CTRL_B, 8'h00);
    rdc("mf_a", vic_pkg::OFS_MF_A, 8'h00);
    rdc("mf_b", vic_pkg::OFS_MF_B, 8'h00);
    rdc("edge", vic_pkg::OFS_EDGE, 8'h00);
    rdc("unmapped", 8'h18, 8'h00);
    chk("pslverr", {31'h0, e}, 32'h1);
    forceFull <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = 6'($random(seed));
      rv = $random(seed);
      wr(vic_pkg::OFS_CTRL_A, rv[7:0]);
      rdc("ctrl_a", vic_pkg::OFS_CTRL_A, rv[7:0] & 8'h7f);
      wr(vic_pkg::OFS_CTRL_B, rv[15:8]);
      rdc("ctrl_b", vic_pkg::OFS_CTRL_B, rv[15:8] & 8'h77);
      wr(vic_pkg::OFS_MF_A, {rv[23:20] & ~rv[19:16], rv[19:16]});
      rdc("mf_a", vic_pkg::OFS_MF_A, {rv[23:20] & ~rv[19:16], rv[19:16]});
      wr(vic_pkg::OFS_EDGE, {2'h0, m});
      rdc("edge", vic_pkg::OFS_EDGE, {4'h0, m[3:0]});
    end
    $display("test registers done");
    // each event sets its flag; sub-events also raise the common flag
    for (int i = 0; i < 9; i++) begin
      wr(vic_pkg::OFS_CTRL_A, 8'h00);
      wr(vic_pkg::OFS_CTRL_B, 8'h00);
      wr(vic_pkg::OFS_MF_A, 8'h0f);
      wr(vic_pkg::OFS_MF_B, 8'h07);
      @(posedge core_clk);
      src[11-i] <= 1'b1;
      @(posedge core_clk);
      src[11-i] <= 1'b0;
      rdc("event flag", EV_OFS[i], EV_EXP[i]);
      if (i >= 3) begin
        rdc("common flag", vic_pkg::OFS_CTRL_B, 8'h40);
      end
    end
    // timer event held across a software clear of its flag
    src[11] <= 1'b1;
    wr(vic_pkg::OFS_CTRL_A, 8'h00);
    src[11] <= 1'b0;
    rdc("set wins", vic_pkg::OFS_CTRL_A, 8'h40);
    forceFull <= 1'b0;
    $display("test events done");
    // edge select codes on both pins, peripheral pin on falling edge only
    for (int c = 0; c < 4; c++) begin
      wr(vic_pkg::OFS_EDGE, {4'h0, 2'(c), 2'(c)});
      wr(vic_pkg::OFS_CTRL_A, 8'h00);
      wr(vic_pkg::OFS_MF_A, 8'h00);
      @(posedge core_clk);
      src[2:0] <= 3'h0;
      repeat (2) @(posedge core_clk);
      rdc("pin fall", vic_pkg::OFS_CTRL_A, c[1] ? 8'h30 : 8'h00);
      rdc("periph fall", vic_pkg::OFS_MF_A, 8'h80);
      wr(vic_pkg::OFS_CTRL_A, 8'h00);
      wr(vic_pkg::OFS_MF_A, 8'h00);
      @(posedge core_clk);
      src[2:0] <= 3'h7;
      repeat (2) @(posedge core_clk);
      rdc("pin rise", vic_pkg::OFS_CTRL_A, c[0] ? 8'h30 : 8'h00);
      rdc("periph rise", vic_pkg::OFS_MF_A, 8'h00);
    end
    wr(vic_pkg::OFS_EDGE, 8'h00);
    $display("test pins done");
    // priority, vectors, blocking, automatic clears and return
    for (int k = 0; k < 6; k++) begin
      m = (6'($random(seed)) | (6'h1 << k)) & (6'h3f << k);
      m2 = m & ~(6'h1 << k);
      wr(vic_pkg::OFS_CTRL_B, {1'b0, m[5:3], 4'h7});
      wr(vic_pkg::OFS_CTRL_A, {1'b0, m[2:0], 4'he});
      repeat (10) @(posedge core_clk);
      forceFull <= 1'b1;
      wr(vic_pkg::OFS_CTRL_A, {1'b0, m[2:0], 4'hf});
      repeat (10) @(posedge core_clk);
      expQ.push_back({9'h000, vic_pkg::VECTOR[k]});
      forceFull <= 1'b0;
      drain();
      rdc("ctrl_a after entry", vic_pkg::OFS_CTRL_A, {1'b0, m2[2:0], 4'he});
      rdc("ctrl_b after entry", vic_pkg::OFS_CTRL_B, {1'b0, m2[5:3], 4'h7});
      rdc("status", vic_pkg::OFS_STATUS, vic_pkg::VECTOR[k]);
      expQ.push_back({1'b1, 4'h0, lastPush});
      @(posedge core_clk);
      retCmd <= 1'b1;
      @(posedge core_clk);
      retCmd <= 1'b0;
      drain();
    end
    $display("test priority done");
    complete_run();
  end
endmodule

// [tb/vic_core_model.sv]
// core sequencer stand-in: phase pulses, program counter and return stack
module vic_core_model #(
  parameter int DEPTH = 2
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              forceFull,
  input  wire logic              retCmd,
  input  wire vic_pkg::vic_cpu_t cpu,
  output logic                   corePhasePulse,
  output logic                   stackFull,
  output logic                   returnFromInterrupt,
  output logic [11:0]            pcNext,
  output logic [11:0]            stackTopData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] stackMem [DEPTH];
  int          sp;
  logic [1:0]  phaseCnt;

  // phase counter, fetch address and stack pointer
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp <= 0;
      phaseCnt <= 2'h0;
      pcNext <= 12'h100;
    end else begin
      phaseCnt <= phaseCnt + 2'h1;
      pcNext <= cpu.pcLoad ? cpu.pcLoadValue[11:0] : pcNext + 12'h001;
      if (cpu.stackPush && sp < DEPTH) begin
        stackMem[sp] <= cpu.stackPushData[11:0];
        sp <= sp + 1;
      end
      if (cpu.stackPop && sp > 0) begin
        sp <= sp - 1;
      end
    end
  end

  // outputs; an empty stack shows a scrambled word, not a stale one
  assign corePhasePulse = (phaseCnt == 2'h0);
  assign stackFull = forceFull || (sp >= DEPTH);
  assign returnFromInterrupt = retCmd;
  assign stackTopData = (sp > 0) ? stackMem[sp-1] : ~pcNext;
endmodule
